// ==== sbs_defines.vh ====
`ifndef SBS_DEFINES_VH
`define SBS_DEFINES_VH

// ****************************************
// Command encodings {ras_n,cas_n,we_n}
// ****************************************
`define SBS_CMD_NOP   3'h7
`define SBS_CMD_ACT   3'h3
`define SBS_CMD_PRE   3'h2
`define SBS_CMD_READ  3'h5
`define SBS_CMD_WRITE 3'h4
`define SBS_CMD_REF   3'h1
`define SBS_CMD_MRS   3'h0

// ****************************************
// Address fields
// ****************************************
`define SBS_AP_BIT    10

// ****************************************
// Timing in ps (tMRD and burst in clocks), clock period in ps
// ****************************************
`define SBS_TCK_PS    5000
`define SBS_TRP_PS    15000
`define SBS_TRCD_PS   15000
`define SBS_TWR_PS    15000
`define SBS_TRC_PS    55000
`define SBS_TMRD_CK   2
`define SBS_BURST_CK  4
`define SBS_CYC(ps)   (((ps) + `SBS_TCK_PS - 1) / `SBS_TCK_PS)

`endif

// ==== sbs_bank.v ====
`timescale 1ns/10ps
`include "sbs_defines.vh"

// ****************************************
// One bank state machine
// ****************************************
module sbs_bank #(
	parameter TRP   = `SBS_CYC(`SBS_TRP_PS),
	parameter TRCD  = `SBS_CYC(`SBS_TRCD_PS),
	parameter TWR   = `SBS_CYC(`SBS_TWR_PS),
	parameter BURST = `SBS_BURST_CK
) (
	// Clock and reset
	input  wire       clk,
	input  wire       nrst,
	// Decoded command for this bank
	input  wire       sel,
	input  wire [2:0] cmd,
	input  wire       ap,
	// State
	output reg  [7:0] state,
	output wire       idle,
	output reg        illegal
);
	localparam S_IDLE = 8'h01;
	localparam S_ACTV = 8'h02;
	localparam S_RDA  = 8'h04;
	localparam S_WRA  = 8'h08;
	localparam S_PRE  = 8'h10;
	localparam S_RACT = 8'h20;
	localparam S_WR   = 8'h40;
	localparam S_WRAP = 8'h80;

	reg [7:0] cnt;
	reg [7:0] next_state;
	reg [7:0] next_cnt;
	reg       next_illegal;
	wire      quiet = !sel || cmd == `SBS_CMD_NOP;
	wire      done  = cnt <= 8'h01;

	assign idle = state == S_IDLE;

	always @* begin
		next_state   = state;
		next_cnt     = done ? 8'h00 : cnt - 8'h01;
		next_illegal = 1'b0;
		case (state)
			S_IDLE: begin
				if (sel && cmd == `SBS_CMD_ACT) begin
					next_state = S_RACT;
					next_cnt   = TRCD[7:0];
				end
			end
			S_ACTV: begin
				if (sel && cmd == `SBS_CMD_PRE) begin
					next_state = S_PRE;
					next_cnt   = TRP[7:0];
				end else if (sel && cmd == `SBS_CMD_WRITE) begin
					next_state = ap ? S_WRA : S_WR;
					// Auto-precharge recovery is timed in its own state
					next_cnt   = ap ? BURST[7:0] : BURST[7:0] + TWR[7:0];
				end else if (sel && cmd == `SBS_CMD_READ && ap) begin
					next_state = S_RDA;
					next_cnt   = BURST[7:0];
				end
			end
			S_RDA: begin
				next_illegal = !quiet;
				if (done) begin
					next_state = S_PRE;
					next_cnt   = TRP[7:0];
				end
			end
			S_WRA: begin
				next_illegal = !quiet;
				if (done) begin
					next_state = S_WRAP;
					next_cnt   = TWR[7:0];
				end
			end
			S_PRE: begin
				// Repeated precharge is harmless and keeps the timer
				next_illegal = !quiet && cmd != `SBS_CMD_PRE;
				if (done)
					next_state = S_IDLE;
			end
			S_RACT: begin
				next_illegal = !quiet;
				if (done)
					next_state = S_ACTV;
			end
			S_WR: begin
				if (sel && cmd == `SBS_CMD_WRITE) begin
					next_state = ap ? S_WRA : S_WR;
					next_cnt   = ap ? BURST[7:0] : BURST[7:0] + TWR[7:0];
				end else begin
					next_illegal = !quiet;
					if (done)
						next_state = S_ACTV;
				end
			end
			S_WRAP: begin
				next_illegal = !quiet;
				if (done) begin
					next_state = S_PRE;
					next_cnt   = TRP[7:0];
				end
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state   <= S_IDLE;
			cnt     <= 8'h00;
			illegal <= 1'b0;
		end else begin
			state   <= next_state;
			cnt     <= next_cnt;
			illegal <= next_illegal;
		end
	end
endmodule

// ==== sbs_top.v ====
`timescale 1ns/10ps
`include "sbs_defines.vh"

// Operation
// - Decode command from select and strobe levels
// - Auto-precharge burst accepts only deselect, NOP
// - Precharge goes idle after tRP
// - Activating bank becomes active after tRCD
// - Write recovery allows new write only
// - Auto-precharge recovery enters precharge after tWR
// - Refresh blocks all commands for tRC
// - Mode set blocks all commands for tMRD
module sbs_top #(
	parameter NBANK = 8,
	parameter BAW   = 3,
	parameter TRC   = `SBS_CYC(`SBS_TRC_PS),
	parameter TMRD  = `SBS_TMRD_CK
) (
	// Clock and reset
	input  wire             clk,
	input  wire             nrst,
	// Command pins
	input  wire             cs_n,
	input  wire             ras_n,
	input  wire             cas_n,
	input  wire             we_n,
	input  wire [BAW-1:0]   ba,
	input  wire [13:0]      addr,
	// Status
	output wire [NBANK-1:0] bank_idle,
	output reg              dev_busy,
	output reg              cmd_illegal
);
	// ****************************************
	// Command decode
	// ****************************************
	localparam D_IDLE = 3'h1;
	localparam D_REF  = 3'h2;
	localparam D_MRS  = 3'h4;

	// Deselect folds into NOP
	wire [2:0] cmd = cs_n ? `SBS_CMD_NOP : {ras_n, cas_n, we_n};
	wire       ap  = addr[`SBS_AP_BIT];
	wire       quiet = cmd == `SBS_CMD_NOP;
	wire       all_idle = &bank_idle;

	reg  [2:0]       dstate;
	reg  [2:0]       next_dstate;
	reg  [7:0]       dcnt;
	reg  [7:0]       next_dcnt;
	reg              next_illegal;
	wire [NBANK-1:0] bank_bad;
	wire             dev_cmd = cmd == `SBS_CMD_REF || cmd == `SBS_CMD_MRS;
	wire             all_pre = cmd == `SBS_CMD_PRE && ap;

	// ****************************************
	// Per bank state
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < NBANK; g = g + 1) begin : bank
			wire [31:0] bank_num = g;
			// Bank only sees commands while the device is not busy
			wire hit = dstate == D_IDLE && !dev_cmd &&
				(ba == bank_num[BAW-1:0] || all_pre);
			sbs_bank u_bank (
				.clk     (clk),
				.nrst    (nrst),
				.sel     (hit),
				.cmd     (cmd),
				.ap      (ap),
				.state   (),
				.idle    (bank_idle[g]),
				.illegal (bank_bad[g])
			);
		end
	endgenerate

	// ****************************************
	// Device wide refresh and mode set
	// ****************************************
	always @* begin
		next_dstate  = dstate;
		next_dcnt    = dcnt <= 8'h01 ? 8'h00 : dcnt - 8'h01;
		next_illegal = 1'b0;
		case (dstate)
			D_IDLE: begin
				if (cmd == `SBS_CMD_REF) begin
					next_illegal = !all_idle;
					next_dstate  = D_REF;
					next_dcnt    = TRC[7:0];
				end else if (cmd == `SBS_CMD_MRS) begin
					next_illegal = !all_idle;
					next_dstate  = D_MRS;
					next_dcnt    = TMRD[7:0];
				end
			end
			D_REF: begin
				next_illegal = !quiet;
				if (dcnt <= 8'h01)
					next_dstate = D_IDLE;
			end
			D_MRS: begin
				next_illegal = !quiet;
				if (dcnt <= 8'h01)
					next_dstate = D_IDLE;
			end
			default: begin
				next_dstate = D_IDLE;
			end
		endcase
	end

	// Error flag is a one-cycle pulse, one edge after a device command or any command while busy, two edges after a bank command otherwise
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dstate      <= D_IDLE;
			dcnt        <= 8'h00;
			dev_busy    <= 1'b0;
			cmd_illegal <= 1'b0;
		end else begin
			dstate      <= next_dstate;
			dcnt        <= next_dcnt;
			dev_busy    <= next_dstate != D_IDLE;
			cmd_illegal <= next_illegal | (|bank_bad);
		end
	end
endmodule

// ==== sbs_checker.sv ====
`timescale 1ns/10ps
`include "sbs_defines.vh"
module sbs_checker #(
	parameter int TRC  = 11,
	parameter int TMRD = 2
) (
	// Clock, reset, pins
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic [2:0]  ba,
	input wire logic [13:0] addr,
	// Status
	input wire logic [7:0]  bank_idle,
	input wire logic        dev_busy,
	input wire logic        cmd_illegal
);
	localparam int TRC1  = TRC - 1;
	localparam int TMRD1 = TMRD - 1;
	wire [2:0] cmd    = {ras_n, cas_n, we_n};
	wire       is_cmd = !cs_n && cmd != `SBS_CMD_NOP;
	wire       ok     = &bank_idle && !dev_busy;
	wire       act0   = is_cmd && cmd == `SBS_CMD_ACT && ba == 3'h0;
	wire       rd     = is_cmd && cmd == `SBS_CMD_READ;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_cs_deselect: assert property (cs_n && ok |=> !dev_busy && &bank_idle)
		else $error("deselect changed state");
	a_flag_cause: assert property (cmd_illegal |-> $past(is_cmd) || $past(is_cmd, 2))
		else $error("flag without command");
	a_act_leave: assert property (act0 && ok |=> !bank_idle[0])
		else $error("activate left bank idle");
	a_act_again: assert property (act0 && ok ##1 act0 |-> ##2 cmd_illegal)
		else $error("activate while activating not flagged");
	a_rdap_again: assert property (rd && addr[`SBS_AP_BIT] && !dev_busy ##1 rd && ba == $past(ba) |-> ##2 cmd_illegal)
		else $error("read during auto precharge read not flagged");
	a_ref_span: assert property (is_cmd && cmd == `SBS_CMD_REF && ok |-> ##1 dev_busy ##TRC1 dev_busy ##1 !dev_busy)
		else $error("refresh busy span wrong");
	a_mrs_span: assert property (is_cmd && cmd == `SBS_CMD_MRS && ok |-> ##1 dev_busy ##TMRD1 dev_busy ##1 !dev_busy)
		else $error("mode set busy span wrong");
	a_busy_flag: assert property (dev_busy && is_cmd |=> cmd_illegal)
		else $error("command while busy not flagged");
endmodule

bind sbs_top sbs_checker #(.TRC(TRC), .TMRD(TMRD)) u_sbs_checker (.clk(clk), .nrst(nrst), .cs_n(cs_n),
	.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .bank_idle(bank_idle),
	.dev_busy(dev_busy), .cmd_illegal(cmd_illegal));

// ==== sbs_ctrl_model.sv ====
`timescale 1ns/10ps
module sbs_ctrl_model (
	// Clock
	input  wire logic   clk,
	// Command pins
	output logic        cs_n,
	output logic        ras_n,
	output logic        cas_n,
	output logic        we_n,
	output logic [2:0]  ba,
	output logic [13:0] addr
);
	initial begin
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'h7;
		ba = 3'h0;
		addr = 14'h0000;
	end
	// Held one edge; caller spaces commands by bank state
	task automatic issue(input logic [2:0] c, input logic [2:0] b, input logic ap);
		@(posedge clk);
		cs_n <= 1'b0;
		{ras_n, cas_n, we_n} <= c;
		ba <= b;
		addr <= {3'h0, ap, 10'h000};
	endtask
	// Deselect scrambles unowned lines; bursts never cut short
	task automatic nop(input int n);
		repeat (n) begin
			@(posedge clk);
			cs_n <= 1'b1;
			{ras_n, cas_n, we_n} <= ~{ras_n, cas_n, we_n};
			ba <= ~ba;
			addr <= ~addr;
		end
	endtask
endmodule

// ==== sbs_top_tb.sv ====
`timescale 1ns/10ps
`include "sbs_defines.vh"
module sbs_top_tb;
	logic        clk, nrst, cs_n, ras_n, cas_n, we_n, dev_busy, cmd_illegal, seen;
	logic [2:0]  ba;
	logic [13:0] addr;
	logic [7:0]  bank_idle;
	int          n_errors, compares, cyc;
	sbs_top u_sbs_top (.clk(clk), .nrst(nrst), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.ba(ba), .addr(addr), .bank_idle(bank_idle), .dev_busy(dev_busy), .cmd_illegal(cmd_illegal));
	sbs_ctrl_model u_sbs_ctrl_model (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.ba(ba), .addr(addr));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Sticky so a late flag is not missed
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cmd_illegal === 1'b1)
			seen <= 1'b1;
		if (cyc == 3000) begin
			n_errors++;
			stop_test;
		end
	end
	task automatic stop_test;
		$display("Errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic send(input logic [2:0] c, input logic [2:0] b, input logic ap);
		u_sbs_ctrl_model.issue(c, b, ap);
	endtask
	task automatic nops(input int n);
		u_sbs_ctrl_model.nop(n);
		#1;
	endtask
	// Bank flag lands two edges late, so four edges cover it
	task automatic ill(input logic exp);
		nops(4);
		chk(seen, exp);
		seen = 1'b0;
	endtask
	task automatic t_act_pre;
		send(`SBS_CMD_ACT, 3'h0, 1'b0);
		send(`SBS_CMD_ACT, 3'h0, 1'b0);
		ill(1'b1);
		chk(bank_idle[0], 1'b0);
		send(`SBS_CMD_PRE, 3'h0, 1'b0);
		send(`SBS_CMD_PRE, 3'h0, 1'b0);
		nops(1);
		chk(bank_idle[0], 1'b0);
		ill(1'b0);
		chk(bank_idle[0], 1'b1);
		// Read during precharge is flagged
		send(`SBS_CMD_ACT, 3'h0, 1'b0);
		nops(3);
		send(`SBS_CMD_PRE, 3'h0, 1'b0);
		send(`SBS_CMD_READ, 3'h0, 1'b0);
		ill(1'b1);
	endtask
	task automatic t_wr;
		send(`SBS_CMD_ACT, 3'h1, 1'b0);
		send(`SBS_CMD_ACT, 3'h5, 1'b0);
		nops(5);
		send(`SBS_CMD_WRITE, 3'h1, 1'b0);
		ill(1'b0);
		chk(bank_idle[5], 1'b0);
		send(`SBS_CMD_WRITE, 3'h1, 1'b0);
		ill(1'b0);
		send(`SBS_CMD_READ, 3'h1, 1'b0);
		ill(1'b1);
		nops(8);
		chk(bank_idle[1], 1'b0);
		// Precharge-all closes both open rows
		send(`SBS_CMD_PRE, 3'h6, 1'b1);
		ill(1'b0);
		chk(bank_idle[1], 1'b1);
		chk(bank_idle[5], 1'b1);
	endtask
	task automatic t_auto;
		send(`SBS_CMD_ACT, 3'h2, 1'b0);
		nops(5);
		send(`SBS_CMD_WRITE, 3'h2, 1'b1);
		ill(1'b0);
		send(`SBS_CMD_WRITE, 3'h2, 1'b0);
		ill(1'b1);
		chk(bank_idle[2], 1'b0);
		nops(2);
		chk(bank_idle[2], 1'b1);
		send(`SBS_CMD_ACT, 3'h3, 1'b0);
		nops(5);
		send(`SBS_CMD_READ, 3'h3, 1'b1);
		send(`SBS_CMD_READ, 3'h3, 1'b0);
		ill(1'b1);
		nops(5);
		chk(bank_idle[3], 1'b1);
	endtask
	task automatic t_dev;
		chk(&bank_idle, 1'b1);
		send(`SBS_CMD_REF, 3'h0, 1'b0);
		nops(2);
		chk(dev_busy, 1'b1);
		send(`SBS_CMD_ACT, 3'h4, 1'b0);
		ill(1'b1);
		chk(dev_busy, 1'b1);
		nops(8);
		chk(dev_busy, 1'b0);
		chk(bank_idle[4], 1'b1);
		send(`SBS_CMD_MRS, 3'h0, 1'b0);
		send(`SBS_CMD_PRE, 3'h5, 1'b0);
		ill(1'b1);
		chk(dev_busy, 1'b0);
	endtask
	initial begin
		nrst = 1'b0;
		seen = 1'b0;
		n_errors = 0;
		compares = 0;
		cyc = 0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		t_act_pre;
		t_wr;
		t_auto;
		t_dev;
		stop_test;
	end
endmodule
